//--- ghr_map.svh
// offsets, fields, codes and reset values of the input-event report block
// included by the package, the edge detector, the report generator and the bench; definitions only
`ifndef GHR_MAP_SVH
`define GHR_MAP_SVH

// ==========================================
// register byte offsets
`define GHR_A_CTRL    8'h00
`define GHR_A_USG_TGT 8'h04
`define GHR_A_USG_SET 8'h08
`define GHR_A_IRQ_CFG 8'h0C
`define GHR_A_POL     8'h10
`define GHR_A_MAP_TGT 8'h14
`define GHR_A_MAP_SET 8'h18
`define GHR_A_REPORTS 8'h1C
`define GHR_A_USG_RD  8'h20
`define GHR_A_ISTAT   8'h24
`define GHR_A_ICLR    8'h28
`define GHR_A_IEN     8'h2C

// ==========================================
// bus answers
`define GHR_OKAY   2'b00
`define GHR_SLVERR 2'b10

// ==========================================
// command fields
`define GHR_F_LO   7:0
`define GHR_F_MID  15:8
`define GHR_F_PIN  9:8
`define GHR_F_EDGE 17:16
`define GHR_F_LVL  16
`define GHR_F_BIT  18:16
`define GHR_F_PAGE 31:24
`define GHR_F_LEN  3:0
`define GHR_F_ID   31:16
`define GHR_F_IDHI 31:24
`define GHR_F_IRQ  2:0
`define GHR_F_GO   0

// ==========================================
// report pages, usable bits, length codes
`define GHR_PG_KBD   8'h07
`define GHR_PG_CON   8'h0C
`define GHR_PG_TEL   8'h0B
`define GHR_MASK_KBD 8'h0C
`define GHR_MASK_CON 8'hD7
`define GHR_MASK_TEL 8'h03
`define GHR_LEN_ONE  4'h9
`define GHR_LEN_TWO  4'hA
`define GHR_NPIN     8'h04
`define GHR_EDGE_BOTH 2'h3

// ==========================================
// reset values
`define GHR_PIN0_BIT 3'h2
`define GHR_PIN1_BIT 3'h3
`define GHR_RST_POL  4'hF
`define GHR_U_F23    16'h0072
`define GHR_U_F24    16'h0073
`define GHR_U_VOLDN  16'h00EA
`define GHR_U_VOLUP  16'h00E9
`define GHR_U_VOICE  16'h00CF
`define GHR_U_MUTE   16'h00E2
`define GHR_U_SEARCH 16'h0221
`define GHR_U_STOP   16'h0226
`define GHR_U_PMUTE  16'h002F
`define GHR_U_HOOK   16'h0020

`endif

//--- ghr_pkg.sv
// state types of the input-event report block
// expects ghr_map.svh beside it
`include "ghr_map.svh"

package ghr_pkg;

	// ==========================================
	// per-pin edge detector
	typedef struct packed {
		logic prev;
		logic primed;
		logic asrt;
		logic dsrt;
	} ghr_edge_t;

	// ==========================================
	// report generator; report index 0..2 stands for report 1..3
	typedef struct packed {
		logic             awHave;
		logic [7:0]       awAddr;
		logic             wHave;
		logic [31:0]      wData;
		logic             bValid;
		logic [1:0]       bResp;
		logic             rValid;
		logic [31:0]      rData;
		logic [1:0]       rResp;
		logic             started;
		logic [1:0]       tgtRpt;
		logic [2:0]       tgtBit;
		logic             tgtOk;
		logic [23:0][15:0] usage;
		logic [1:0]       mapPin;
		logic [3:0]       mapOk;
		logic [3:0][1:0]  mapRpt;
		logic [3:0][2:0]  mapBit;
		logic [3:0][1:0]  edgeSel;
		logic [3:0]       actHigh;
		logic [2:0][7:0]  bits;
		logic [2:0][7:0]  armed;
		logic [2:0]       pend;
		logic             rptValid;
		logic             rptNak;
		logic [1:0]       rptId;
		logic [7:0]       rptData;
		logic [2:0]       irqStat;
		logic [2:0]       irqEn;
	} ghr_state_t;

endpackage : ghr_pkg

//--- ghr_edge.sv
// edge detector for one general input pin
// pin is synchronous to clk_sys; polarity and edge enables come from registers
`timescale 1ns/1ps
`include "ghr_map.svh"

module ghr_edge
	import ghr_pkg::*;
(
	input  wire logic       clk_sys,  // system clock
	input  wire logic       arst_n,   // async reset, active low
	input  wire logic       pinIn,    // pin level
	input  wire logic       actHigh,  // 1 active high, 0 active low
	input  wire logic [1:0] edgeSel,  // bit0 rising, bit1 falling irq enable
	output logic            asrt,     // asserting edge strobe
	output logic            dsrt      // de-asserting edge strobe
);

	ghr_edge_t s;
	ghr_edge_t next_s;
	logic      rise;
	logic      fall;

	// ==========================================
	// edge classification
	always_comb begin
		next_s = s;
		// first sample after reset only primes, so no false edge
		rise = s.primed && pinIn && !s.prev;
		fall = s.primed && !pinIn && s.prev;
		next_s.prev = pinIn;
		next_s.primed = 1'b1;
		next_s.asrt = (rise && edgeSel[0] && actHigh) || (fall && edgeSel[1] && !actHigh);
		next_s.dsrt = (fall && edgeSel[1] && actHigh) || (rise && edgeSel[0] && !actHigh);
	end

	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign asrt = s.asrt;
	assign dsrt = s.dsrt;

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	property p_low_assert;
		s.primed && !actHigh && edgeSel[1] && $fell(pinIn) |=> asrt && !dsrt;
	endproperty
	a_low_assert: assert property (p_low_assert) else $error("falling edge of low pin not asserting");

	property p_high_release;
		s.primed && actHigh && edgeSel == `GHR_EDGE_BOTH ##1 $fell(pinIn) |=> dsrt;
	endproperty
	a_high_release: assert property (p_high_release) else $error("release edge missed");

endmodule : ghr_edge

//--- ghr_report_gen.sv
// input-event report generator: pins to three one-byte HID reports
// AXI4-Lite slave for commands; host poll port answered one cycle later
`timescale 1ns/1ps
`include "ghr_map.svh"

// How it works
// - three reports, keyboard, consumer and telephony, each holding many events.
// - report 1 is page 7, report 2 page 12, report 3 page 11.
// - default byte-0 layouts; unlisted bits are reserved and stay zero.
// - a target whose page disagrees with the report is refused.
// - usage target latches report, byte, bit, page for the next set.
// - length code 9 means one-byte id, 10 two-byte; others refused.
// - usage ids change only before USB operation has started.
// - each report bit's page and usage id can be read back.
// - enabled pin edges update reports with no software help.
// - asserting edge sets bit, release arms it, sending clears armed bits.
// - no event: send the report, or NAK when the host set idle.
// - reset map: pin 0 to F23, pin 1 to F24, pins 2-3 none.
// - irq config takes reserved zero, pin and edge select, 3 both.
// - polarity takes reserved zero, pin and level; 0 means active low.
// - map target picks a pin; map set gives report, byte, bit.
// - map changes are accepted before and after USB start.
// - map set naming a reserved bit is ignored, old map kept.
module ghr_report_gen
	import ghr_pkg::*;
(
	input  wire logic        clk_sys,        // 40 MHz system clock
	input  wire logic        arst_n,         // async reset, active low
	input  wire logic [7:0]  s_axi_awaddr,   // write address
	input  wire logic        s_axi_awvalid,  // write address valid
	output logic             s_axi_awready,  // write address ready
	input  wire logic [31:0] s_axi_wdata,    // write data
	input  wire logic [3:0]  s_axi_wstrb,    // byte strobes
	input  wire logic        s_axi_wvalid,   // write data valid
	output logic             s_axi_wready,   // write data ready
	output logic [1:0]       s_axi_bresp,    // write response
	output logic             s_axi_bvalid,   // write response valid
	input  wire logic        s_axi_bready,   // write response ready
	input  wire logic [7:0]  s_axi_araddr,   // read address
	input  wire logic        s_axi_arvalid,  // read address valid
	output logic             s_axi_arready,  // read address ready
	output logic [31:0]      s_axi_rdata,    // read data
	output logic [1:0]       s_axi_rresp,    // read response
	output logic             s_axi_rvalid,   // read data valid
	input  wire logic        s_axi_rready,   // read data ready
	input  wire logic [3:0]  inPin,          // general input pins
	input  wire logic        pollReq,        // host poll strobe
	input  wire logic [1:0]  pollId,         // polled report 1..3
	input  wire logic        hostIdle,       // host has set idle
	output logic             rptValid,       // report sent strobe
	output logic             rptNak,         // NAK strobe
	output logic [1:0]       rptId,          // report id answered
	output logic [7:0]       rptData,        // report byte
	output logic             irq             // level interrupt
);

	// ==========================================
	// decoding helpers
	function automatic logic [7:0] pageOf(input logic [1:0] idx);
		unique case (idx)
			2'h0:    pageOf = `GHR_PG_KBD;
			2'h1:    pageOf = `GHR_PG_CON;
			2'h2:    pageOf = `GHR_PG_TEL;
			default: pageOf = 8'h00;
		endcase
	endfunction : pageOf

	function automatic logic usable(input logic [1:0] idx, input logic [2:0] b);
		logic [7:0] m;
		unique case (idx)
			2'h0:    m = `GHR_MASK_KBD;
			2'h1:    m = `GHR_MASK_CON;
			2'h2:    m = `GHR_MASK_TEL;
			default: m = 8'h00;
		endcase
		usable = m[b];
	endfunction : usable

	function automatic logic [31:0] strbMask(input logic [3:0] st);
		strbMask = {{8{st[3]}}, {8{st[2]}}, {8{st[1]}}, {8{st[0]}}};
	endfunction : strbMask

	function automatic ghr_state_t rstVal();
		ghr_state_t r;
		r = '0;
		r.usage[5'h02] = `GHR_U_F23;
		r.usage[5'h03] = `GHR_U_F24;
		r.usage[5'h0F] = `GHR_U_VOLDN;
		r.usage[5'h0E] = `GHR_U_VOLUP;
		r.usage[5'h0C] = `GHR_U_VOICE;
		r.usage[5'h0A] = `GHR_U_MUTE;
		r.usage[5'h09] = `GHR_U_SEARCH;
		r.usage[5'h08] = `GHR_U_STOP;
		r.usage[5'h11] = `GHR_U_PMUTE;
		r.usage[5'h10] = `GHR_U_HOOK;
		r.mapOk = 4'h3;
		r.mapBit[0] = `GHR_PIN0_BIT;
		r.mapBit[1] = `GHR_PIN1_BIT;
		r.actHigh = `GHR_RST_POL;
		return r;
	endfunction : rstVal

	localparam ghr_state_t RST_STATE = rstVal();

	ghr_state_t s;
	ghr_state_t next_s;
	logic [3:0] asrt;
	logic [3:0] dsrt;

	// ==========================================
	// pin edge detectors
	genvar gi;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_pin
			ghr_edge u_edge (
				.clk_sys (clk_sys),
				.arst_n  (arst_n),
				.pinIn   (inPin[gi]),
				.actHigh (s.actHigh[gi]),
				.edgeSel (s.edgeSel[gi]),
				.asrt    (asrt[gi]),
				.dsrt    (dsrt[gi])
			);
		end
	endgenerate

	assign s_axi_awready = !s.awHave && !s.bValid;
	assign s_axi_wready  = !s.wHave && !s.bValid;
	assign s_axi_arready = !s.rValid;

	// ==========================================
	// next state
	always_comb begin
		logic [31:0] d;
		logic [2:0]  clr;
		logic [2:0]  ev;
		logic [1:0]  idx;
		logic        ok;
		d = s.wData;
		clr = 3'h0;
		ev = 3'h0;
		idx = 2'h0;
		ok = 1'b0;
		next_s = s;
		next_s.rptValid = 1'b0;
		next_s.rptNak = 1'b0;

		if (s_axi_awvalid && s_axi_awready) begin
			next_s.awHave = 1'b1;
			next_s.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.wHave = 1'b1;
			next_s.wData = s_axi_wdata & strbMask(s_axi_wstrb);
		end
		if (s.bValid && s_axi_bready) begin
			next_s.bValid = 1'b0;
		end
		if (s.rValid && s_axi_rready) begin
			next_s.rValid = 1'b0;
		end

		// reads
		if (s_axi_arvalid && s_axi_arready) begin
			next_s.rValid = 1'b1;
			next_s.rResp = `GHR_OKAY;
			next_s.rData = 32'h0000_0000;
			unique case (s_axi_araddr)
				`GHR_A_CTRL:    next_s.rData = {31'h0, s.started};
				`GHR_A_REPORTS: next_s.rData = {8'h00, s.bits[2], s.bits[1], s.bits[0]};
				`GHR_A_USG_RD:  next_s.rData = {pageOf(s.tgtRpt), 7'h00, s.tgtOk,
					s.usage[{s.tgtRpt, s.tgtBit}]};
				`GHR_A_ISTAT:   next_s.rData = {29'h0, s.irqStat};
				`GHR_A_IEN:     next_s.rData = {29'h0, s.irqEn};
				`GHR_A_USG_TGT, `GHR_A_USG_SET, `GHR_A_IRQ_CFG, `GHR_A_POL,
				`GHR_A_MAP_TGT, `GHR_A_MAP_SET, `GHR_A_ICLR: next_s.rData = 32'h0000_0000;
				default:        next_s.rResp = `GHR_SLVERR;
			endcase
		end

		// writes, taken once address and data are both held
		if (s.awHave && s.wHave && !s.bValid) begin
			next_s.awHave = 1'b0;
			next_s.wHave = 1'b0;
			next_s.bValid = 1'b1;
			next_s.bResp = `GHR_OKAY;
			unique case (s.awAddr)
				`GHR_A_CTRL: begin
					// start is one-way: usage ids lock until reset
					if (d[`GHR_F_GO]) next_s.started = 1'b1;
				end
				`GHR_A_USG_TGT: begin
					idx = 2'(d[`GHR_F_LO] - 8'h01);
					ok = d[`GHR_F_LO] >= 8'h01 && d[`GHR_F_LO] <= 8'h03 && d[`GHR_F_MID] == 8'h00
						&& usable(idx, d[`GHR_F_BIT]) && d[`GHR_F_PAGE] == pageOf(idx);
					next_s.tgtRpt = idx;
					next_s.tgtBit = d[`GHR_F_BIT];
					next_s.tgtOk = ok;
					ev[2] = !ok;
				end
				`GHR_A_USG_SET: begin
					if (s.started || !s.tgtOk) begin
						ev[2] = 1'b1;
					end else if (d[`GHR_F_LEN] == `GHR_LEN_ONE && d[`GHR_F_IDHI] == 8'h00) begin
						next_s.usage[{s.tgtRpt, s.tgtBit}] = d[`GHR_F_ID];
					end else if (d[`GHR_F_LEN] == `GHR_LEN_TWO) begin
						next_s.usage[{s.tgtRpt, s.tgtBit}] = d[`GHR_F_ID];
					end else begin
						ev[2] = 1'b1;
					end
				end
				`GHR_A_IRQ_CFG: begin
					if (d[`GHR_F_LO] != 8'h00 || d[`GHR_F_MID] >= `GHR_NPIN) begin
						ev[2] = 1'b1;
					end else begin
						next_s.edgeSel[d[`GHR_F_PIN]] = d[`GHR_F_EDGE];
					end
				end
				`GHR_A_POL: begin
					if (d[`GHR_F_LO] != 8'h00 || d[`GHR_F_MID] >= `GHR_NPIN) begin
						ev[2] = 1'b1;
					end else begin
						next_s.actHigh[d[`GHR_F_PIN]] = d[`GHR_F_LVL];
					end
				end
				`GHR_A_MAP_TGT: begin
					if (d[`GHR_F_LO] != 8'h00 || d[`GHR_F_MID] >= `GHR_NPIN) begin
						ev[2] = 1'b1;
					end else begin
						next_s.mapPin = d[`GHR_F_PIN];
					end
				end
				`GHR_A_MAP_SET: begin
					// allowed whether or not USB has started
					idx = 2'(d[`GHR_F_LO] - 8'h01);
					ok = d[`GHR_F_LO] >= 8'h01 && d[`GHR_F_LO] <= 8'h03 && d[`GHR_F_MID] == 8'h00
						&& usable(idx, d[`GHR_F_BIT]);
					if (ok) begin
						next_s.mapOk[s.mapPin] = 1'b1;
						next_s.mapRpt[s.mapPin] = idx;
						next_s.mapBit[s.mapPin] = d[`GHR_F_BIT];
					end else begin
						ev[2] = 1'b1;
					end
				end
				`GHR_A_ICLR:    clr = d[`GHR_F_IRQ];
				`GHR_A_IEN:     next_s.irqEn = d[`GHR_F_IRQ];
				`GHR_A_REPORTS, `GHR_A_USG_RD, `GHR_A_ISTAT: ;
				default:        next_s.bResp = `GHR_SLVERR;
			endcase
		end

		// host poll: clear first, so a same-cycle pin event still lands
		if (pollReq) begin
			next_s.rptId = pollId;
			idx = 2'(pollId - 2'h1);
			if (pollId == 2'h0 || (!s.pend[idx] && hostIdle)) begin
				next_s.rptNak = 1'b1;
			end else begin
				next_s.rptValid = 1'b1;
				next_s.rptData = s.bits[idx];
				next_s.bits[idx] = s.bits[idx] & ~s.armed[idx];
				next_s.armed[idx] = 8'h00;
				next_s.pend[idx] = 1'b0;
				ev[1] = 1'b1;
			end
		end

		// pin events, serviced with no software step
		for (int p = 0; p < 4; p++) begin
			if (asrt[p] && s.mapOk[p]) begin
				next_s.bits[s.mapRpt[p]][s.mapBit[p]] = 1'b1;
				next_s.armed[s.mapRpt[p]][s.mapBit[p]] = 1'b0;
				next_s.pend[s.mapRpt[p]] = 1'b1;
				ev[0] = 1'b1;
			end
			if (dsrt[p] && s.mapOk[p]) begin
				next_s.armed[s.mapRpt[p]][s.mapBit[p]] = 1'b1;
				next_s.pend[s.mapRpt[p]] = 1'b1;
			end
		end

		// set wins over a same-cycle clear
		next_s.irqStat = (s.irqStat & ~clr) | ev;
	end

	// ==========================================
	// state register
	always_ff @(posedge clk_sys or negedge arst_n) begin
		if (!arst_n) begin
			s <= RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	assign s_axi_bvalid = s.bValid;
	assign s_axi_bresp  = s.bResp;
	assign s_axi_rvalid = s.rValid;
	assign s_axi_rdata  = s.rData;
	assign s_axi_rresp  = s.rResp;
	assign rptValid     = s.rptValid;
	assign rptNak       = s.rptNak;
	assign rptId        = s.rptId;
	assign rptData      = s.rptData;
	assign irq          = |(s.irqStat & s.irqEn);

	// ==========================================
	// checks
	default clocking cb @(posedge clk_sys);
	endclocking
	default disable iff (!arst_n);

	property p_poll_answer;
		pollReq |=> rptValid != rptNak;
	endproperty
	a_poll_answer: assert property (p_poll_answer) else $error("poll not answered");

	property p_idle_nak;
		pollReq && pollId == 2'h2 && !s.pend[1] && hostIdle |=> rptNak && rptId == 2'h2;
	endproperty
	a_idle_nak: assert property (p_idle_nak) else $error("idle poll not NAKed");

	property p_send_clears;
		pollReq && pollId == 2'h1 && asrt == 4'h0 && (s.pend[0] || !hostIdle) |=>
			(s.bits[0] & $past(s.armed[0])) == 8'h00 && rptData == $past(s.bits[0]);
	endproperty
	a_send_clears: assert property (p_send_clears) else $error("armed bit kept after send");

	property p_set_on_assert;
		asrt[2] && s.mapOk[2] && s.mapRpt[2] == 2'h1 |=> s.bits[1][$past(s.mapBit[2])];
	endproperty
	a_set_on_assert: assert property (p_set_on_assert) else $error("asserting edge lost");

	property p_usage_locked;
		s.started |=> $stable(s.usage) && s.started;
	endproperty
	a_usage_locked: assert property (p_usage_locked) else $error("usage changed after start");

	property p_rsvd_clear;
		(s.bits[0] & ~`GHR_MASK_KBD) == 8'h00 && (s.bits[1] & ~`GHR_MASK_CON) == 8'h00
			&& (s.bits[2] & ~`GHR_MASK_TEL) == 8'h00;
	endproperty
	a_rsvd_clear: assert property (p_rsvd_clear) else $error("reserved report bit set");

	property p_target_page;
		s.tgtOk |-> usable(s.tgtRpt, s.tgtBit) && pageOf(s.tgtRpt) != 8'h00;
	endproperty
	a_target_page: assert property (p_target_page) else $error("bad usage target kept");

	property p_map_usable;
		s.mapOk[2] |-> usable(s.mapRpt[2], s.mapBit[2]);
	endproperty
	a_map_usable: assert property (p_map_usable) else $error("pin mapped to reserved bit");

	cover property (pollReq && hostIdle ##1 rptNak);
	cover property (pollReq && s.armed[0] != 8'h00 ##1 rptValid);
	cover property (s.awHave && s.wHave && s.awAddr == `GHR_A_MAP_SET && s.started);
	cover property (irq);

endmodule : ghr_report_gen

//--- ghr_host_model.sv
// host side: polls the report endpoint and holds the idle setting
// assumes the report generator answers a poll one cycle after taking it
`timescale 1ns/1ps

module ghr_host_model (
	input  wire logic       clk_sys,   // system clock
	output logic            pollReq,   // poll strobe
	output logic [1:0]      pollId,    // polled report
	output logic            hostIdle,  // idle set by host
	input  wire logic       rptValid,  // report sent
	input  wire logic       rptNak,    // NAK
	input  wire logic [7:0] rptData    // report byte
);
	initial begin
		pollReq  = 1'b0;
		pollId   = 2'h0;
		hostIdle = 1'b0;
	end

	// caller sits just after a rising edge; answer is {nak, valid}
	task automatic poll(input logic [1:0] id, input logic idle, output logic [1:0] ans,
		output logic [7:0] dat);
		pollReq  <= 1'b1;
		pollId   <= id;
		hostIdle <= idle;
		@(posedge clk_sys);
		pollReq <= 1'b0;
		pollId  <= ~id;  // released id never repeats the last value
		@(negedge clk_sys);
		ans = {rptNak, rptValid};
		dat = rptData;
		@(posedge clk_sys);
	endtask : poll
endmodule : ghr_host_model

//--- tb_top.sv
// self-checking bench for the input-event report generator
// commands over AXI4-Lite, polls through the host model
`timescale 1ns/1ps
`include "ghr_map.svh"

module tb_top;
	logic        clk_sys, arst_n, awValid, awReady, wValid, wReady, bValid, bReady;
	logic        arValid, arReady, rValid, rReady, pollReq, hostIdle, rptValid, rptNak, irq;
	logic [7:0]  awAddr, arAddr, rptData;
	logic [31:0] wData, rData;
	logic [1:0]  bResp, rResp, pollId, rptId;
	logic [3:0]  inPin;
	int          numErrors, comparisons;

	ghr_report_gen dut (.clk_sys(clk_sys), .arst_n(arst_n), .s_axi_awaddr(awAddr),
		.s_axi_awvalid(awValid), .s_axi_awready(awReady), .s_axi_wdata(wData),
		.s_axi_wstrb(4'hF), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid),
		.s_axi_rready(rReady), .inPin(inPin), .pollReq(pollReq), .pollId(pollId),
		.hostIdle(hostIdle), .rptValid(rptValid), .rptNak(rptNak), .rptId(rptId),
		.rptData(rptData), .irq(irq));

	ghr_host_model host (.clk_sys(clk_sys), .pollReq(pollReq), .pollId(pollId),
		.hostIdle(hostIdle), .rptValid(rptValid), .rptNak(rptNak), .rptData(rptData));

	initial begin
		clk_sys = 1'b0;
		forever #12.5 clk_sys = ~clk_sys;
	end

	// ==========================================
	// shared tasks
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		comparisons++;
		if (seen !== exp) begin
			numErrors++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check

	task automatic stop_test;
		$display("comparisons %0d mismatches %0d", comparisons, numErrors);
		if (numErrors == 0 && comparisons > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : stop_test

	task automatic tick(inout int n);
		n++;
		if (n > 60) begin
			numErrors++;
			$display("[FAIL] %0t no answer", $time);
			stop_test();
		end
	endtask : tick

	// address and data offered together, each dropped when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic aw, w, tA, tW;
		logic [1:0] rs;
		int n;
		{aw, w, n} = {2'b11, 32'd0};
		awAddr <= a;
		wData <= d;
		// bready and rready stay high between transfers: no same-step toggle
		{awValid, wValid, bReady} <= 3'b111;
		while (aw || w) begin
			@(negedge clk_sys);
			{tA, tW} = {aw && awReady, w && wReady};
			@(posedge clk_sys);
			if (tA) awValid <= 1'b0;
			if (tW) wValid <= 1'b0;
			{aw, w} = {aw && !tA, w && !tW};
			tick(n);
		end
		tA = 1'b0;
		while (!tA) begin
			@(negedge clk_sys);
			{tA, rs} = {bValid, bResp};
			@(posedge clk_sys);
			tick(n);
		end
		check(rs, `GHR_OKAY);
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input logic [1:0] r);
		logic got;
		logic [31:0] d;
		logic [1:0] rs;
		int n;
		{got, n} = {1'b0, 32'd0};
		arAddr <= a;
		{arValid, rReady} <= 2'b11;
		while (!got) begin
			@(negedge clk_sys);
			got = arReady;
			@(posedge clk_sys);
			tick(n);
		end
		arValid <= 1'b0;
		got = 1'b0;
		while (!got) begin
			@(negedge clk_sys);
			{got, d, rs} = {rValid, rData, rResp};
			@(posedge clk_sys);
			tick(n);
		end
		check(d, e);
		check(rs, r);
	endtask : rd

	// four cycles cover the two-sample edge path
	task automatic pins(input logic [3:0] v);
		inPin <= v;
		repeat (4) @(posedge clk_sys);
	endtask : pins

	task automatic poll(input logic [1:0] id, input logic idle, input logic [1:0] ea,
		input logic [7:0] ed);
		logic [1:0] ans;
		logic [7:0] dat;
		host.poll(id, idle, ans, dat);
		check(ans, ea);
		check(rptId, id);
		if (ea == 2'b01) check(dat, ed);
	endtask : poll

	task automatic irq_is(input logic e);
		@(negedge clk_sys);
		check(irq, e);
		@(posedge clk_sys);
	endtask : irq_is

	// ==========================================
	// scenarios
	task automatic t_reset;
		rd(`GHR_A_REPORTS, 32'h0, `GHR_OKAY);
		rd(`GHR_A_IEN, 32'h0, `GHR_OKAY);
		rd(8'h30, 32'h0, `GHR_SLVERR);
		poll(2'h1, 1'b0, 2'b01, 8'h00);
		$display("reset test done");
	endtask : t_reset

	task automatic t_usage;
		wr(`GHR_A_USG_TGT, 32'h0B00_0003);
		rd(`GHR_A_USG_RD, {16'h0B01, `GHR_U_HOOK}, `GHR_OKAY);
		wr(`GHR_A_USG_TGT, 32'h0C01_0002);
		wr(`GHR_A_USG_SET, 32'h008C_0009);
		rd(`GHR_A_USG_RD, 32'h0C01_008C, `GHR_OKAY);
		wr(`GHR_A_USG_TGT, 32'h0701_0002);
		wr(`GHR_A_USG_SET, 32'h00AA_0009);
		wr(`GHR_A_USG_TGT, 32'h0C01_0002);
		rd(`GHR_A_USG_RD, 32'h0C01_008C, `GHR_OKAY);
		wr(`GHR_A_USG_SET, 32'h1234_000A);
		wr(`GHR_A_USG_SET, 32'h5555_000B);
		rd(`GHR_A_USG_RD, 32'h0C01_1234, `GHR_OKAY);
		wr(`GHR_A_CTRL, 32'h1);
		rd(`GHR_A_CTRL, 32'h1, `GHR_OKAY);
		wr(`GHR_A_USG_SET, 32'h0077_0009);
		rd(`GHR_A_USG_RD, 32'h0C01_1234, `GHR_OKAY);
		$display("usage test done");
	endtask : t_usage

	task automatic t_events;
		wr(`GHR_A_IRQ_CFG, 32'h0003_0000);
		wr(`GHR_A_IRQ_CFG, 32'h0003_0100);
		pins(4'h3);
		rd(`GHR_A_REPORTS, 32'h0C, `GHR_OKAY);
		poll(2'h1, 1'b0, 2'b01, 8'h0C);
		rd(`GHR_A_REPORTS, 32'h0C, `GHR_OKAY);
		pins(4'h2);
		poll(2'h1, 1'b0, 2'b01, 8'h0C);
		rd(`GHR_A_REPORTS, 32'h08, `GHR_OKAY);
		poll(2'h1, 1'b1, 2'b10, 8'h00);
		$display("event test done");
	endtask : t_events

	task automatic t_map;
		wr(`GHR_A_MAP_TGT, 32'h0000_0200);
		wr(`GHR_A_MAP_SET, 32'h0004_0002);
		wr(`GHR_A_POL, 32'h0000_0200);
		wr(`GHR_A_IRQ_CFG, 32'h0003_0200);
		pins(4'h6);
		rd(`GHR_A_REPORTS, 32'h0008, `GHR_OKAY);
		pins(4'h2);
		rd(`GHR_A_REPORTS, 32'h1008, `GHR_OKAY);
		poll(2'h2, 1'b0, 2'b01, 8'h10);
		poll(2'h2, 1'b1, 2'b10, 8'h00);
		$display("map test done");
	endtask : t_map

	task automatic t_refuse;
		wr(`GHR_A_ICLR, 32'h7);
		wr(`GHR_A_IEN, 32'h4);
		rd(`GHR_A_IEN, 32'h4, `GHR_OKAY);
		irq_is(1'b0);
		wr(`GHR_A_MAP_TGT, 32'h0000_0100);
		wr(`GHR_A_MAP_SET, 32'h0005_0003);
		rd(`GHR_A_ISTAT, 32'h4, `GHR_OKAY);
		irq_is(1'b1);
		pins(4'h0);
		poll(2'h1, 1'b0, 2'b01, 8'h08);
		rd(`GHR_A_REPORTS, 32'h1000, `GHR_OKAY);
		wr(`GHR_A_ICLR, 32'h4);
		irq_is(1'b0);
		$display("refusal test done");
	endtask : t_refuse

	initial begin
		{numErrors, comparisons} = {32'd0, 32'd0};
		{arst_n, awValid, wValid, bReady, arValid, rReady} = 6'h00;
		{awAddr, arAddr, wData, inPin} = {8'h00, 8'h00, 32'h0, 4'h0};
		repeat (10) @(posedge clk_sys);
		arst_n <= 1'b1;
		@(posedge clk_sys);
		t_reset();
		t_usage();
		t_events();
		t_map();
		t_refuse();
		stop_test();
	end
endmodule : tb_top
